// ==== fault_code_regs.svh ====
`ifndef FAULT_CODE_REGS_SVH
`define FAULT_CODE_REGS_SVH
`define FLT_GROUP_W 3
`define FLT_SRC_W 7
`define FLT_GROUP_HEALTHY 3'h0
`define FLT_CODE_RST 3'h0
`define FLT_PIN_RST 3'h0
`define FLT_ALARM_RST 1'h1
`endif

// ==== fault_code_pkg.sv ====
`include "fault_code_regs.svh"
package fault_code_pkg;
   typedef logic [`FLT_GROUP_W-1:0] group_t;
   typedef logic [`FLT_SRC_W-1:0] src_t;
   typedef enum logic [0:0] {ST_HEALTHY, ST_LATCHED} latch_state_e;
endpackage : fault_code_pkg

// ==== fault_pin_sync.sv ====
`timescale 1ns/10ps
`default_nettype none
// three-stage synchroniser per bit; a change is taken once stages two and three agree
module fault_pin_sync
(
   input wire logic ref_clk_i,           // system clock
   input wire logic nrst_i,              // async reset, active low
   input wire logic [6:0] async_i,       // raw detector levels
   output logic [6:0] sync_o             // filtered levels
);
   logic [6:0] s1_r;
   logic [6:0] s2_r;
   logic [6:0] s3_r;
   logic [6:0] sync_nxt;
   logic [6:0] out_r;

   genvar g;
   generate
      for (g = 0; g < 7; g = g + 1)
      begin : g_bit
         assign sync_nxt[g] = (s2_r[g] == s3_r[g]) ? s3_r[g] : out_r[g];
      end
   endgenerate

   always_ff @(posedge ref_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         s1_r <= 7'h00;
         s2_r <= 7'h00;
         s3_r <= 7'h00;
         out_r <= 7'h00;
      end
      else
      begin
         s1_r <= async_i;
         s2_r <= s1_r;
         s3_r <= s2_r;
         out_r <= sync_nxt;
      end
   end

   assign sync_o = out_r;
endmodule : fault_pin_sync
`default_nettype wire

// ==== fault_group_code_encoder.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "fault_code_regs.svh"
module fault_group_code_encoder
(
   input wire logic ref_clk_i,                    // system clock, 250 MHz
   input wire logic nrst_i,                       // async reset, active low
   input wire fault_code_pkg::src_t fault_det_i,  // bit n-1: group n detector active
   input wire logic fault_clear_i,                // same-clock pulse: clear latched fault
   input wire logic code_as_gpo_i,                // 1: code pins act as extra outputs
   input wire logic [2:0] gpo_i,                  // extra output levels, 1 = ON
   output logic fault_code_low_bit_n_o,           // low code pin, low = ON
   output logic fault_code_mid_bit_n_o,           // mid code pin, low = ON
   output logic fault_code_high_bit_n_o,          // high code pin, low = ON
   output logic alarm_n_o,                        // alarm pair, low = fault present
   output fault_code_pkg::group_t group_o         // latched group number
);
   import fault_code_pkg::*;

   // ****************************************************
   // input conditioning
   // ****************************************************
   // detectors sit in other blocks with their own timing, so every bit is filtered
   src_t det_s;

   fault_pin_sync u_sync
   (
      .ref_clk_i (ref_clk_i),
      .nrst_i (nrst_i),
      .async_i (fault_det_i),
      .sync_o (det_s)
   );

   // ****************************************************
   // group latch
   // ****************************************************
   latch_state_e state_r;
   latch_state_e state_nxt;
   group_t group_r;
   group_t group_nxt;
   group_t pick;

   // fixed priority only breaks ties inside one cycle; lowest group wins
   always_comb
   begin
      pick = `FLT_GROUP_HEALTHY;
      for (int i = `FLT_SRC_W - 1; i >= 0; i--)
      begin
         if (det_s[i])
            pick = group_t'(i + 1);
      end
   end

   always_comb
   begin
      state_nxt = state_r;
      group_nxt = group_r;
      case (state_r)
         ST_HEALTHY:
         begin
            if (det_s != '0)
            begin
               state_nxt = ST_LATCHED;
               group_nxt = pick;
            end
         end
         ST_LATCHED:
         begin
            // clear only takes effect once every detector has gone quiet,
            // so a still-present fault is never lost by a clear
            if (fault_clear_i && det_s == '0)
            begin
               state_nxt = ST_HEALTHY;
               group_nxt = `FLT_GROUP_HEALTHY;
            end
         end
         default:
         begin
            state_nxt = ST_HEALTHY;
            group_nxt = `FLT_GROUP_HEALTHY;
         end
      endcase
   end

   always_ff @(posedge ref_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         state_r <= ST_HEALTHY;
         group_r <= `FLT_CODE_RST;
      end
      else
      begin
         state_r <= state_nxt;
         group_r <= group_nxt;
      end
   end

   // ****************************************************
   // pin encoding
   // ****************************************************
   logic [2:0] on_lvl;
   logic [2:0] pin_nxt;
   logic [2:0] pin_r;
   logic alarm_nxt;
   logic alarm_r;

   // the code pins carry group_r as is: a one bit is a released (OFF) pin
   always_comb
   begin
      // group g: code bits ON where g has a zero (0 -> all ON, 7 -> all OFF)
      on_lvl = ~group_r;
      // same mapping covers groups 4..7
      if (code_as_gpo_i)
         on_lvl = gpo_i;
      pin_nxt = ~on_lvl;
      alarm_nxt = ~(state_r == ST_LATCHED);
   end

   // reset leaves the pins at group zero with the alarm released
   always_ff @(posedge ref_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         pin_r <= `FLT_PIN_RST;      // group zero: all ON, pulled low
         alarm_r <= `FLT_ALARM_RST;
      end
      else
      begin
         pin_r <= pin_nxt;
         alarm_r <= alarm_nxt;
      end
   end

   assign fault_code_low_bit_n_o = pin_r[0];
   assign fault_code_mid_bit_n_o = pin_r[1];
   assign fault_code_high_bit_n_o = pin_r[2];
   assign alarm_n_o = alarm_r;
   assign group_o = group_r;

   // ****************************************************
   // checks
   // ****************************************************
   // the pin checks lag group_r by one edge, as the pins are registered
   sequence s_first_fault;
      state_r == ST_HEALTHY && det_s != '0;
   endsequence

   sequence s_latch_taken;
      state_r == ST_LATCHED && group_r == $past(pick);
   endsequence

   sequence s_alarm_on;
      !alarm_n_o;
   endsequence

   sequence s_release_req;
      state_r == ST_LATCHED && fault_clear_i && det_s == '0;
   endsequence

   property p_healthy_all_on;
      @(posedge ref_clk_i) disable iff (!nrst_i)
      (state_r == ST_HEALTHY && !code_as_gpo_i) |=> (pin_r == 3'h0);
   endproperty
   a_healthy_all_on: assert property (p_healthy_all_on) else $error("healthy code not all on");

   property p_code_is_group;
      @(posedge ref_clk_i) disable iff (!nrst_i)
      !code_as_gpo_i |=> (pin_r == $past(group_r));
   endproperty
   a_code_is_group: assert property (p_code_is_group) else $error("pin code mismatches group");

   property p_group_seven;
      @(posedge ref_clk_i) disable iff (!nrst_i)
      (group_r == 3'h7 && !code_as_gpo_i) |=> (pin_r == 3'h7);
   endproperty
   a_group_seven: assert property (p_group_seven) else $error("group seven not all off");

   property p_gpo_map;
      @(posedge ref_clk_i) disable iff (!nrst_i)
      code_as_gpo_i |=> (pin_r == ~$past(gpo_i));
   endproperty
   a_gpo_map: assert property (p_gpo_map) else $error("extra outputs not inverted levels");

   property p_alarm_tracks;
      @(posedge ref_clk_i) disable iff (!nrst_i)
      s_first_fault |=> s_latch_taken ##1 s_alarm_on;
   endproperty
   a_alarm_tracks: assert property (p_alarm_tracks) else $error("alarm or group late");

   property p_hold;
      @(posedge ref_clk_i) disable iff (!nrst_i)
      (state_r == ST_LATCHED && !(fault_clear_i && det_s == '0)) |=> $stable(group_r);
   endproperty
   a_hold: assert property (p_hold) else $error("latched group changed");

   property p_low_first;
      @(posedge ref_clk_i) disable iff (!nrst_i)
      (state_r == ST_HEALTHY && det_s[0]) |=> (group_r == 3'h1);
   endproperty
   a_low_first: assert property (p_low_first) else $error("priority broken");

   property p_set_wins;
      @(posedge ref_clk_i) disable iff (!nrst_i)
      (state_r == ST_LATCHED && det_s != '0) |=> (state_r == ST_LATCHED && $stable(group_r));
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("latch lost with fault");

   // a held clear is harmless: it acts on the first quiet cycle
   property p_clear_release;
      @(posedge ref_clk_i) disable iff (!nrst_i)
      s_release_req |=> (group_r == `FLT_GROUP_HEALTHY) ##1 alarm_n_o;
   endproperty
   a_clear_release: assert property (p_clear_release) else $error("no release");

   property p_alarm_idle;
      @(posedge ref_clk_i) disable iff (!nrst_i)
      ($past(state_r) == ST_HEALTHY) |-> alarm_n_o;
   endproperty
   a_alarm_idle: assert property (p_alarm_idle) else $error("alarm while healthy");
endmodule : fault_group_code_encoder
`default_nettype wire

// ==== fault_reader.sv ====
`timescale 1ns/10ps
`default_nettype none
// ***************************************************
// controller side: samples the sinking pins
// ***************************************************
module fault_reader
(
   input wire logic low_n_i,   // low code pin
   input wire logic mid_n_i,   // mid code pin
   input wire logic high_n_i,  // high code pin
   input wire logic alarm_n_i, // alarm pair, low = fault
   output logic valid_o,       // code is meaningful
   output logic [2:0] group_o  // decoded group
);
   // code only trusted while alarm is active
   assign valid_o = ~alarm_n_i;
   // a pulled-low pin is ON, so ON reads as 0
   assign group_o = {high_n_i, mid_n_i, low_n_i};
endmodule : fault_reader
`default_nettype wire

// ==== tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   import fault_code_pkg::*;
   // ***************************************************
   // stimulus and design
   // ***************************************************
   logic clk;
   logic nrst;
   src_t det;
   logic clr;
   logic gmode;
   logic [2:0] gpo;
   logic lo_n;
   logic mid_n;
   logic hi_n;
   logic alarm_n;
   group_t grp;
   logic valid;
   logic [2:0] seen;
   int miscompares;
   int checks;
   fault_group_code_encoder dut (.ref_clk_i(clk), .nrst_i(nrst), .fault_det_i(det),
      .fault_clear_i(clr), .code_as_gpo_i(gmode), .gpo_i(gpo),
      .fault_code_low_bit_n_o(lo_n), .fault_code_mid_bit_n_o(mid_n),
      .fault_code_high_bit_n_o(hi_n), .alarm_n_o(alarm_n), .group_o(grp));
   fault_reader reader (.low_n_i(lo_n), .mid_n_i(mid_n), .high_n_i(hi_n),
      .alarm_n_i(alarm_n), .valid_o(valid), .group_o(seen));
   // ***************************************************
   // shared tasks
   // ***************************************************
   task automatic wrap_up();
      if (miscompares == 0 && checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : wrap_up
   task automatic check(input string what, input logic [3:0] got, input logic [3:0] exp);
      checks++;
      if (got !== exp)
      begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   // bounded wait for the alarm pin to reach a level
   task automatic wait_alarm(input logic lvl);
      int n;
      n = 0;
      while (alarm_n !== lvl && n < 30)
      begin
         @(negedge clk);
         n++;
      end
      @(negedge clk);
      if (alarm_n !== lvl)
      begin
         miscompares++;
         wrap_up();
      end
   endtask : wait_alarm
   task automatic release_all();
      det = 7'h00;
      clr = 1'b1;
      wait_alarm(1'b1);
      clr = 1'b0;
      check("healthy", {1'b0, seen}, 4'h0);
   endtask : release_all
   // ***************************************************
   // scenarios
   // ***************************************************
   task automatic each_group();
      for (int g = 1; g < 8; g++)
      begin
         det = 7'(1 << (g - 1));
         wait_alarm(1'b0);
         check("valid", {3'h0, valid}, 4'h1);
         check("pins", {1'b0, seen}, 4'(g));
         check("group", {1'b0, grp}, 4'(g));
         release_all();
      end
   endtask : each_group
   task automatic first_wins();
      det = 7'h10;
      wait_alarm(1'b0);
      det = 7'h14;
      clr = 1'b1;
      repeat (8) @(negedge clk);
      check("held", {alarm_n, seen}, 4'h5);
      release_all();
   endtask : first_wins
   task automatic tie_break();
      det = 7'h60;
      wait_alarm(1'b0);
      check("tie", {1'b0, grp}, 4'h6);
      release_all();
   endtask : tie_break
   task automatic mid_reset();
      det = 7'h40;
      wait_alarm(1'b0);
      det = 7'h00;
      nrst = 1'b0;
      repeat (3) @(negedge clk);
      nrst = 1'b1;
      @(negedge clk);
      check("rst pins", {alarm_n, seen}, 4'h8);
      check("rst group", {1'b0, grp}, 4'h0);
   endtask : mid_reset
   task automatic as_outputs();
      gmode = 1'b1;
      gpo = 3'h5;
      repeat (3) @(negedge clk);
      check("gpo", {alarm_n, seen}, 4'hA);
      gpo = 3'h2;
      repeat (3) @(negedge clk);
      check("gpo", {alarm_n, seen}, 4'hD);
      gmode = 1'b0;
      repeat (3) @(negedge clk);
      check("code", {alarm_n, seen}, 4'h8);
   endtask : as_outputs
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   initial
   begin
      miscompares = 0;
      checks = 0;
      nrst = 1'b0;
      det = 7'h00;
      clr = 1'b0;
      gmode = 1'b0;
      gpo = 3'h0;
      repeat (10) @(negedge clk);
      nrst = 1'b1;
      @(negedge clk);
      check("reset", {alarm_n, seen}, 4'h8);
      each_group();
      first_wins();
      tie_break();
      mid_reset();
      as_outputs();
      wrap_up();
   end
endmodule : tb_top
`default_nettype wire
